// ==== csa_ctrl.sv ====
// Chip-select decode and drive-output configuration for two sockets.
// Assumes host strobes are one-cycle pulses synchronous to ref_clk.
//
// Function
// - Size code picks decoded block size
// - Space bit selects memory or I/O decode
// - Sharing needs steering, share bit, global bit
// - Shared IRQ pulses low four clocks minimum
// - Unshared level high; shared open-drain low pulse
// - Enabled: upper five bits drive address 25:21
// - Enable bit picks normal or output use
// - Float host bit 7 on drive-port reads
// - Select bit routes BVD2 to speaker/LED on I/O cards
// - Decode config at 3E and 7E
// - Drive output control at 3F and 7F
// - I/O compares A9:2 with AEN low; memory A23:16
// - Locked until index writes 0E then 37
// - Select pin only with select function code
`timescale 1ns/10ps
`include "csa_consts.svh"

module csa_ctrl
#(
   parameter int PULSE_CYC = `CSA_IRQ_PULSE_CYC
)
(
   // Clock, reset, enable
   input  wire logic            ref_clk,
   input  wire logic            resetn,
   input  wire logic            clk_en,
   // Indexed register port
   input  wire logic            index_wr,
   input  wire logic            data_wr,
   input  wire logic            data_rd,
   input  wire logic [7:0]      host_wdata,
   output logic      [7:0]      host_rdata,
   // ISA cycle qualifiers
   input  wire logic [23:0]     isa_addr,
   input  wire logic            isa_aen,
   input  wire logic            isa_mem_cycle,
   input  wire logic            isa_io_cycle,
   input  wire logic            isa_io_read,
   output logic                 host_bit7_float,
   // Settings held elsewhere
   input  wire logic            global_irq_share,
   input  wire logic [1:0]      status_irq_steered,
   input  wire logic [1:0][7:0] select_base,
   input  wire logic [1:0][2:0] pin_function_select,
   // Status interrupt
   input  wire logic [1:0]      status_level,
   input  wire logic [1:0]      status_change,
   output logic      [1:0]      status_irq_out,
   output logic      [1:0]      status_irq_oe,
   // Programmable chip select pin
   output logic      [1:0]      programmable_select_out,
   output logic      [1:0]      programmable_select_oe,
   // Card high address lines
   input  wire logic [1:0][4:0] card_addr_normal,
   output logic      [1:0][4:0] card_high_address_lines,
   // Battery detect 2 routing
   input  wire logic [1:0]      io_card_mode,
   input  wire logic [1:0]      battery_detect2,
   output logic      [1:0]      speaker_in,
   output logic      [1:0]      drive_led_in
);

   csa_pkg::csa_lock_t lk_r;        // Unlock sequencer
   csa_pkg::csa_lock_t lk_nxt;
   logic [7:0]         index_r;     // Current index
   logic [7:0]         index_nxt;
   logic [7:0]         rdata_r;     // Registered read data
   logic [7:0]         rdata_nxt;
   logic [1:0][7:0]    rd_val;      // Per-socket read value, zero when not hit
   logic [1:0]         float_req;   // Per-socket bit 7 float request

   // Unlock sequence and index register
   always_comb
   begin
      lk_nxt    = lk_r;
      index_nxt = index_r;
      if (index_wr)
      begin
         index_nxt = host_wdata;
         if (lk_r != csa_pkg::CSA_LK_OPEN)
         begin
            if (host_wdata[5:0] == `CSA_UNLOCK_FIRST)
               lk_nxt = csa_pkg::CSA_LK_FIRST;
            else if (lk_r == csa_pkg::CSA_LK_FIRST &&
                     host_wdata[5:0] == `CSA_UNLOCK_SECOND)
               lk_nxt = csa_pkg::CSA_LK_OPEN;
            else
               lk_nxt = csa_pkg::CSA_LK_LOCKED;
         end
      end
      else if ((data_wr || data_rd) && lk_r == csa_pkg::CSA_LK_FIRST)
         lk_nxt = csa_pkg::CSA_LK_LOCKED;
   end

   // Read data is captured on the read strobe; misses read zero
   always_comb
   begin
      rdata_nxt = rdata_r;
      if (data_rd)
         rdata_nxt = rd_val[0] | rd_val[1];
   end

   // Common registers; once open, the lock stays open until reset
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         lk_r    <= csa_pkg::CSA_LK_LOCKED;
         index_r <= 8'h00;
         rdata_r <= 8'h00;
      end
      else if (clk_en)
      begin
         lk_r    <= lk_nxt;
         index_r <= index_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign host_rdata = rdata_r;

   // Drive-port read with any socket asking for the float
   assign host_bit7_float = isa_io_read && (|float_req) &&
                            (isa_addr[9:0] == `CSA_DRV_PORT_PRI ||
                             isa_addr[9:0] == `CSA_DRV_PORT_SEC);

   genvar s;
   generate
      for (s = 0; s < 2; s++)
      begin : g_sock
         logic [7:0] cfg_idx;       // Decode config index of this socket
         logic [7:0] ata_idx;       // Drive output index of this socket
         logic       cfg_hit;
         logic       ata_hit;
         logic [7:0] cfg_r;         // Decode configuration
         logic [7:0] cfg_nxt;
         logic [7:0] ata_r;         // Drive output control
         logic [7:0] ata_nxt;
         logic [7:0] mask;          // Address bits that take part in the compare
         logic [7:0] cmp_addr;      // Address slice for the current space
         logic       cyc_ok;        // Cycle of the configured space
         logic       sel_r;         // Chip select, active low
         logic       sel_nxt;
         logic [4:0] ca_r;          // High card address lines
         logic [4:0] ca_nxt;
         logic       share_act;

         assign cfg_idx = (s == 0) ? `CSA_IDX_CFG_A : `CSA_IDX_CFG_B;
         assign ata_idx = (s == 0) ? `CSA_IDX_ATA_A : `CSA_IDX_ATA_B;
         // Locked registers neither answer reads nor take writes
         assign cfg_hit = (lk_r == csa_pkg::CSA_LK_OPEN) && index_r == cfg_idx;
         assign ata_hit = (lk_r == csa_pkg::CSA_LK_OPEN) && index_r == ata_idx;
         // Reserved config bits come back as zero
         assign rd_val[s] = cfg_hit ? (cfg_r & `CSA_CFG_WMASK) :
                            (ata_hit ? ata_r : 8'h00);

         // Register writes; reserved bits are masked off
         always_comb
         begin
            cfg_nxt = cfg_r;
            ata_nxt = ata_r;
            if (data_wr && cfg_hit)
               cfg_nxt = host_wdata & `CSA_CFG_WMASK;
            if (data_wr && ata_hit)
               ata_nxt = host_wdata;
         end

         // Larger blocks drop low compare bits; a misaligned base just
         // ignores its low bits, which is why software must align it
         assign mask = 8'hFF << cfg_r[`CSA_CFG_SIZE_LSB +: 2];
         assign cmp_addr = cfg_r[`CSA_CFG_SPACE_BIT] ? isa_addr[9:2] :
                           isa_addr[23:16];
         assign cyc_ok = cfg_r[`CSA_CFG_SPACE_BIT] ? (isa_io_cycle && !isa_aen)
                                                   : isa_mem_cycle;

         // Select, address-line and pin computations
         always_comb
         begin
            sel_nxt = !(cyc_ok && ((cmp_addr & mask) ==
                                   (select_base[s] & mask)));
            if (ata_r[`CSA_ATA_EN_BIT])
               ca_nxt = ata_r[`CSA_ATA_GPO_LSB +: 5];
            else
               ca_nxt = card_addr_normal[s];
         end

         // Per-socket registers
         always_ff @(posedge ref_clk or negedge resetn)
         begin
            if (!resetn)
            begin
               cfg_r <= `CSA_CFG_RESET;
               ata_r <= `CSA_ATA_RESET;
               sel_r <= 1'b1;
               ca_r  <= 5'h00;
            end
            else if (clk_en)
            begin
               cfg_r <= cfg_nxt;
               ata_r <= ata_nxt;
               sel_r <= sel_nxt;
               ca_r  <= ca_nxt;
            end
         end

         assign programmable_select_out[s] = sel_r;
         assign programmable_select_oe[s]  =
            (pin_function_select[s] == `CSA_PIN_FN_SELECT);
         assign card_high_address_lines[s] = ca_r;
         assign float_req[s] = ata_r[`CSA_ATA_FLOAT_BIT];
         // BVD2 routing applies only to I/O cards
         assign speaker_in[s]   = io_card_mode[s] && !ata_r[`CSA_ATA_LED_BIT] &&
                                  battery_detect2[s];
         assign drive_led_in[s] = io_card_mode[s] && ata_r[`CSA_ATA_LED_BIT] &&
                                  battery_detect2[s];
         assign share_act = status_irq_steered[s] && cfg_r[`CSA_CFG_SHARE_BIT] &&
                            global_irq_share;

         csa_irq_pulse #(.PULSE_CYC(PULSE_CYC)) u_irq
         (
            .ref_clk       (ref_clk),
            .resetn        (resetn),
            .clk_en        (clk_en),
            .share_active  (share_act),
            .status_level  (status_level[s]),
            .status_change (status_change[s]),
            .irq_out       (status_irq_out[s]),
            .irq_oe        (status_irq_oe[s])
         );

         sel_space_a: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
            !sel_r |-> $past(cfg_r[`CSA_CFG_SPACE_BIT] ? isa_io_cycle && !isa_aen
                                                      : isa_mem_cycle))
            else $error("chip select asserted outside a matching cycle");
         gpo_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
            ata_r[`CSA_ATA_EN_BIT] ##1 $stable(ata_r) |->
               ca_r == ata_r[`CSA_ATA_GPO_LSB +: 5])
            else $error("high address lines not driven from outputs");
         share_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
            !global_irq_share |-> status_irq_oe[s])
            else $error("irq shared without global enable");
         reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
            (cfg_r & ~`CSA_CFG_WMASK) == 8'h00)
            else $error("reserved config bits set");
         pin_route_a: assert property (@(posedge ref_clk) disable iff (!resetn)
            (pin_function_select[s] != `CSA_PIN_FN_SELECT) |->
               !programmable_select_oe[s])
            else $error("select pin driven under another function");
      end
   endgenerate

   // All four registers must hold while locked, not just one per socket
   locked_write_a: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
      (lk_r != csa_pkg::CSA_LK_OPEN) && data_wr |=>
         $stable(g_sock[0].cfg_r) && $stable(g_sock[0].ata_r) &&
         $stable(g_sock[1].cfg_r) && $stable(g_sock[1].ata_r))
      else $error("locked register took a write");
   unlock_seq_a: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
      lk_r == csa_pkg::CSA_LK_FIRST && (data_wr || data_rd) && !index_wr |=>
         lk_r == csa_pkg::CSA_LK_LOCKED)
      else $error("data access did not cancel unlock");
   float_port_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      host_bit7_float |-> isa_io_read &&
         (isa_addr[9:0] == `CSA_DRV_PORT_PRI || isa_addr[9:0] == `CSA_DRV_PORT_SEC))
      else $error("bit 7 floated outside a drive-port read");

endmodule

// ==== csa_consts.svh ====
// Constants for the chip-select and drive-output configuration block.
// Assumes inclusion by bare name from the block's design files.
`ifndef CSA_CONSTS_SVH
`define CSA_CONSTS_SVH

// Index offsets of the per-socket registers
`define CSA_IDX_CFG_A      8'h3E
`define CSA_IDX_ATA_A      8'h3F
`define CSA_IDX_CFG_B      8'h7E
`define CSA_IDX_ATA_B      8'h7F

// Unlock sequence: low six index bits of the two index writes
`define CSA_UNLOCK_FIRST   6'h0E
`define CSA_UNLOCK_SECOND  6'h37

// Decode configuration fields
`define CSA_CFG_SIZE_LSB   5
`define CSA_CFG_SPACE_BIT  4
`define CSA_CFG_SHARE_BIT  3
`define CSA_CFG_WMASK      8'h78

// Drive output control fields
`define CSA_ATA_GPO_LSB    3
`define CSA_ATA_FLOAT_BIT  2
`define CSA_ATA_LED_BIT    1
`define CSA_ATA_EN_BIT     0

// Reset values
`define CSA_CFG_RESET      8'h00
`define CSA_ATA_RESET      8'h00

// Drive address ports whose reads may float host bit 7
`define CSA_DRV_PORT_PRI   10'h3F7
`define CSA_DRV_PORT_SEC   10'h377

// Pin function code that routes the chip select to its pin
`define CSA_PIN_FN_SELECT  3'h4

// Shared status interrupt low pulse, in clock periods
`define CSA_IRQ_PULSE_CYC  4

`endif

// ==== csa_pkg.sv ====
// Types shared by the chip-select and drive-output configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package csa_pkg;

   // Unlock sequencer states, one-hot
   typedef enum logic [2:0]
   {
      CSA_LK_LOCKED = 3'h1,
      CSA_LK_FIRST  = 3'h2,
      CSA_LK_OPEN   = 3'h4
   } csa_lock_t;

   // Shared interrupt pulse states, one-hot
   typedef enum logic [1:0]
   {
      CSA_IQ_IDLE  = 2'h1,
      CSA_IQ_PULSE = 2'h2
   } csa_irq_st_t;

endpackage

// ==== csa_irq_pulse.sv ====
// Status interrupt driver for one socket: level or shared low pulse.
// Assumes status_change is a one-cycle pulse synchronous to ref_clk.
`timescale 1ns/10ps
`include "csa_consts.svh"

module csa_irq_pulse
#(
   parameter int PULSE_CYC = `CSA_IRQ_PULSE_CYC
)
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic clk_en,
   // Mode and events
   input  wire logic share_active,
   input  wire logic status_level,
   input  wire logic status_change,
   // IRQ pin, two-signal form
   output logic      irq_out,
   output logic      irq_oe
);

   csa_pkg::csa_irq_st_t st_r;      // Pulse state
   csa_pkg::csa_irq_st_t st_nxt;
   logic [3:0]           cnt_r;     // Remaining low cycles minus one
   logic [3:0]           cnt_nxt;
   logic                 level_r;   // Registered status level
   logic                 level_nxt;

   // Next state: a new change restarts the pulse so it is never cut short
   always_comb
   begin
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      level_nxt = status_level;
      case (st_r)
         csa_pkg::CSA_IQ_IDLE:
         begin
            if (share_active && status_change)
            begin
               st_nxt  = csa_pkg::CSA_IQ_PULSE;
               cnt_nxt = 4'(PULSE_CYC - 1);
            end
         end
         csa_pkg::CSA_IQ_PULSE:
         begin
            if (share_active && status_change)
               cnt_nxt = 4'(PULSE_CYC - 1);
            else if (cnt_r == 4'h0)
               st_nxt = csa_pkg::CSA_IQ_IDLE;
            else
               cnt_nxt = cnt_r - 4'h1;
         end
         default:
         begin
            st_nxt  = csa_pkg::CSA_IQ_IDLE;
            cnt_nxt = 4'h0;
         end
      endcase
   end

   // Registers, frozen while the clock enable is low
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r    <= csa_pkg::CSA_IQ_IDLE;
         cnt_r   <= 4'h0;
         level_r <= 1'b0;
      end
      else if (clk_en)
      begin
         st_r    <= st_nxt;
         cnt_r   <= cnt_nxt;
         level_r <= level_nxt;
      end
   end

   // Shared: open drain, pulled low only during the pulse; else active-high level
   assign irq_out = share_active ? 1'b0 : level_r;
   assign irq_oe  = share_active ? (st_r == csa_pkg::CSA_IQ_PULSE) : 1'b1;

   pulse_len_a: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
      $rose(st_r == csa_pkg::CSA_IQ_PULSE) |-> (irq_oe || !share_active)[*4])
      else $error("shared irq pulse shorter than four clocks");
   // Level follows the status input one enabled edge later, not only level_r
   level_mode_a: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
      !share_active && $past(clk_en) && $past(resetn) |->
         irq_oe && (irq_out == $past(status_level)))
      else $error("unshared irq not driven as a level");

endmodule

// ==== csa_irq_line.sv ====
// Far side of the two status IRQ pins: the ISA interrupt lines.
// Assumes one pull-up per line, so a released pin reads high.
`timescale 1ns/10ps

module csa_irq_line
(
   // Pin from the block, output and enable
   input  wire logic [1:0] irq_out,
   input  wire logic [1:0] irq_oe,
   // Level seen by the interrupt controller
   output logic      [1:0] irq_wire
);
   // Pull-up wins when released; keeps a stale level from passing as a pulse
   always_comb
   begin
      irq_wire = (irq_oe & irq_out) | ~irq_oe;
   end
endmodule

// ==== test_chip_select_and_ata_output_config.sv ====
// Self-checking bench for the chip-select and drive-output configuration block.
// Assumes csa_consts.svh, csa_ctrl and csa_irq_line are compiled first.
`timescale 1ns/10ps
`include "csa_consts.svh"

module test_chip_select_and_ata_output_config;
   // Clock, reset and host register port
   logic            ref_clk = 1'b0;
   logic            resetn = 1'b0;
   logic            clk_en = 1'b1;
   logic            index_wr = 1'b0;
   logic            data_wr = 1'b0;
   logic            data_rd = 1'b0;
   logic [7:0]      host_wdata = 8'h00;
   logic [7:0]      host_rdata;
   // ISA cycle and settings held outside
   logic [23:0]     isa_addr = 24'h00_0000;
   logic            isa_aen = 1'b0;
   logic            isa_mem_cycle = 1'b0;
   logic            isa_io_cycle = 1'b0;
   logic            isa_io_read = 1'b0;
   logic            host_bit7_float;
   logic            global_irq_share = 1'b0;
   logic [1:0]      status_irq_steered = 2'b00;
   logic [1:0][7:0] select_base = '0;
   logic [1:0][2:0] pin_function_select = '0;
   // Status interrupt and pins
   logic [1:0]      status_level = 2'b00;
   logic [1:0]      status_change = 2'b00;
   logic [1:0]      status_irq_out;
   logic [1:0]      status_irq_oe;
   logic [1:0]      irq_wire;
   logic [1:0]      programmable_select_out;
   logic [1:0]      programmable_select_oe;
   logic [1:0][4:0] card_addr_normal = '0;
   logic [1:0][4:0] card_high_address_lines;
   logic [1:0]      io_card_mode = 2'b00;
   logic [1:0]      battery_detect2 = 2'b00;
   logic [1:0]      speaker_in;
   logic [1:0]      drive_led_in;
   // Bench state
   int              error_cnt = 0;
   int              n_checks = 0;
   int              n;
   logic [7:0]      exp_q [$];
   logic            rd_seen = 1'b0;
   logic [7:0]      v;
   logic [7:0]      base;
   logic [7:0]      sl;
   logic [7:0]      idx_tab [4] = '{`CSA_IDX_CFG_A, `CSA_IDX_ATA_A,
                                    `CSA_IDX_CFG_B, `CSA_IDX_ATA_B};

   csa_ctrl csa_ctrl_inst
   (
      .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .index_wr(index_wr),
      .data_wr(data_wr), .data_rd(data_rd), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .isa_addr(isa_addr), .isa_aen(isa_aen),
      .isa_mem_cycle(isa_mem_cycle), .isa_io_cycle(isa_io_cycle),
      .isa_io_read(isa_io_read), .host_bit7_float(host_bit7_float),
      .global_irq_share(global_irq_share), .status_irq_steered(status_irq_steered),
      .select_base(select_base), .pin_function_select(pin_function_select),
      .status_level(status_level), .status_change(status_change),
      .status_irq_out(status_irq_out), .status_irq_oe(status_irq_oe),
      .programmable_select_out(programmable_select_out),
      .programmable_select_oe(programmable_select_oe),
      .card_addr_normal(card_addr_normal), .card_high_address_lines(card_high_address_lines),
      .io_card_mode(io_card_mode), .battery_detect2(battery_detect2),
      .speaker_in(speaker_in), .drive_led_in(drive_led_in)
   );

   csa_irq_line csa_irq_line_inst
   (
      .irq_out(status_irq_out), .irq_oe(status_irq_oe), .irq_wire(irq_wire)
   );

   // 250 MHz clock
   always #2 ref_clk = ~ref_clk;

   // Counts every comparison, reports and counts each mismatch
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // Single verdict point for the main sequence and the watchdog
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One register-port cycle; each strobe is written once per falling edge
   task automatic op(input logic iw, input logic dw, input logic dr, input logic [7:0] d);
      @(negedge ref_clk);
      index_wr   = iw;
      data_wr    = dw;
      data_rd    = dr;
      host_wdata = d;
   endtask

   // Indexed write, then one idle cycle with junk data on the bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      op(1'b1, 1'b0, 1'b0, idx);
      op(1'b0, 1'b1, 1'b0, d);
      op(1'b0, 1'b0, 1'b0, 8'($urandom));
   endtask

   // Indexed read; the expected byte is noted for the monitor
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      op(1'b1, 1'b0, 1'b0, idx);
      op(1'b0, 1'b0, 1'b1, 8'h00);
      exp_q.push_back(e);
      op(1'b0, 1'b0, 1'b0, 8'h00);
   endtask

   // One host cycle on the decoder, select checked one edge later
   task automatic cs(input logic io, input logic aen, input logic [7:0] s, input logic e);
      @(negedge ref_clk);
      isa_io_cycle  = io;
      isa_mem_cycle = !io;
      isa_aen       = aen;
      isa_addr      = io ? {14'($urandom), s, 2'($urandom)} : {s, 16'($urandom)};
      @(negedge ref_clk);
      check("select_out", 24'(programmable_select_out), 24'({e, e}));
      isa_io_cycle  = 1'b0;
      isa_mem_cycle = 1'b0;
   endtask

   // Read monitor: the answer stands one edge after the taken read
   always @(posedge ref_clk)
   begin
      rd_seen <= data_rd;
   end
   always @(negedge ref_clk)
   begin
      if (rd_seen)
         check("host_rdata", 24'(host_rdata), 24'(exp_q.pop_front()));
   end

   // Watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #100_000;
      error_cnt++;
      complete_run();
   end

   initial
   begin
      void'($urandom(32'h7c4d));
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      resetn = 1'b1;
      // Locked writes are dropped; a data access aborts the unlock
      wr(`CSA_IDX_CFG_A, 8'h58);
      rd(`CSA_IDX_CFG_A, 8'h00);
      op(1'b1, 1'b0, 1'b0, 8'h0E);
      op(1'b0, 1'b0, 1'b1, 8'h00);
      exp_q.push_back(8'h00);
      op(1'b1, 1'b0, 1'b0, 8'h37);
      wr(`CSA_IDX_CFG_A, 8'h58);
      op(1'b1, 1'b0, 1'b0, 8'h0E);
      op(1'b1, 1'b0, 1'b0, 8'h37);
      for (int i = 0; i < 4; i++)
         rd(idx_tab[i], 8'h00);
      $display("test unlock done");
      // All four registers, reserved bits, an unmapped index
      for (int i = 0; i < 8; i++)
      begin
         v = (i < 4) ? 8'($urandom) : 8'hFF;
         wr(idx_tab[i % 4], v);
         rd(idx_tab[i % 4], (i % 2) ? v : v & `CSA_CFG_WMASK);
      end
      wr(8'h3D, 8'hFF);
      rd(8'h3D, 8'h00);
      $display("test registers done");
      // Every size code in both spaces, inside, outside, wrong space, DMA
      // Both sockets get the same decode so each select pin is compared
      pin_function_select = {2{`CSA_PIN_FN_SELECT}};
      #1 check("select_oe", 24'(programmable_select_oe), 24'h00_0003);
      for (int sz = 0; sz < 4; sz++)
         for (int io = 0; io < 2; io++)
         begin
            base = 8'($urandom) & (8'hFF << sz);
            select_base = {2{base}};
            wr(`CSA_IDX_CFG_A, {1'b0, 2'(sz), io[0], 4'h0});
            wr(`CSA_IDX_CFG_B, {1'b0, 2'(sz), io[0], 4'h0});
            sl = base | (8'($urandom) & ~(8'hFF << sz));
            cs(io[0], 1'b0, sl, 1'b0);
            cs(io[0], 1'b0, base ^ (8'h01 << sz), 1'b1);
            cs(!io[0], 1'b0, sl, 1'b1);
            if (io)
               cs(1'b1, 1'b1, sl, 1'b1);
         end
      pin_function_select = {2{3'h5}};
      #1 check("select_oe", 24'(programmable_select_oe), 24'h00_0000);
      $display("test chip select done");
      // Socket B still holds all ones; its float bit would hide socket A's
      wr(`CSA_IDX_ATA_B, 8'h00);
      // Per socket: high address lines, BVD2 routing, bit 7 float
      for (int s = 0; s < 2; s++)
      begin
         card_addr_normal[s] = 5'($urandom);
         io_card_mode[s] = 1'b1;
         battery_detect2[s] = 1'b1;
         wr(idx_tab[2 * s + 1], 8'h00);
         @(negedge ref_clk);
         check("ca_lines", 24'(card_high_address_lines[s]), 24'(card_addr_normal[s]));
         check("speaker_in", 24'(speaker_in[s]), 24'h00_0001);
         check("drive_led_in", 24'(drive_led_in[s]), 24'h00_0000);
         v = 8'($urandom) | 8'h01;
         wr(idx_tab[2 * s + 1], v);
         @(negedge ref_clk);
         check("ca_lines", 24'(card_high_address_lines[s]), 24'(v[7:3]));
         wr(idx_tab[2 * s + 1], 8'h06);
         check("drive_led_in", 24'(drive_led_in[s]), 24'h00_0001);
         check("speaker_in", 24'(speaker_in[s]), 24'h00_0000);
         isa_io_read = 1'b1;
         isa_addr = 24'(`CSA_DRV_PORT_PRI);
         #1 check("bit7_float", 24'(host_bit7_float), 24'h00_0001);
         isa_addr = 24'(`CSA_DRV_PORT_SEC);
         #1 check("bit7_float", 24'(host_bit7_float), 24'h00_0001);
         isa_addr = 24'h00_03F6;
         #1 check("bit7_float", 24'(host_bit7_float), 24'h00_0000);
         isa_addr = 24'(`CSA_DRV_PORT_PRI);
         wr(idx_tab[2 * s + 1], 8'h00);
         check("bit7_float", 24'(host_bit7_float), 24'h00_0000);
         isa_io_read = 1'b0;
      end
      $display("test drive outputs done");
      // Level mode, share bit without the global bit, then shared pulse
      wr(`CSA_IDX_CFG_A, 8'h00);
      status_level[0] = 1'b1;
      repeat (2) @(negedge ref_clk);
      check("irq_wire", 24'(irq_wire[0]), 24'h00_0001);
      check("irq_oe", 24'(status_irq_oe[0]), 24'h00_0001);
      status_irq_steered = 2'b01;
      wr(`CSA_IDX_CFG_A, 8'h08);
      status_level[0] = 1'b0;
      repeat (2) @(negedge ref_clk);
      check("irq_oe", 24'(status_irq_oe[0]), 24'h00_0001);
      check("irq_out", 24'(status_irq_out[0]), 24'h00_0000);
      global_irq_share = 1'b1;
      repeat (2) @(negedge ref_clk);
      check("irq_oe", 24'(status_irq_oe[0]), 24'h00_0000);
      status_change[0] = 1'b1;
      @(negedge ref_clk);
      status_change[0] = 1'b0;
      n = 0;
      repeat (8)
      begin
         #1 n += (irq_wire[0] === 1'b0) ? 1 : 0;
         @(negedge ref_clk);
      end
      check("irq_low_cycles", 24'(n), 24'(`CSA_IRQ_PULSE_CYC));
      $display("test status irq done");
      // A low clock enable freezes every register, so this write is lost
      clk_en = 1'b0;
      wr(`CSA_IDX_CFG_A, 8'h70);
      clk_en = 1'b1;
      rd(`CSA_IDX_CFG_A, 8'h08);
      // Let the read monitor take its note before the verdict
      @(negedge ref_clk);
      $display("test clock enable done");
      complete_run();
   end
endmodule
